// File: lsfu_map.svh
`ifndef LSFU_MAP_SVH
`define LSFU_MAP_SVH

// Register offsets (byte addresses on the plain register port)
`define LSFU_OFS_STATUS     8'h00
`define LSFU_OFS_UNDEF      8'h04
`define LSFU_OFS_COMMITS    8'h08

// Bit positions inside the arithmetic status word
`define LSFU_BIT_COND       0
`define LSFU_BIT_ZERO       1
`define LSFU_BIT_NEG        2
`define LSFU_BIT_CARRY      3
`define LSFU_BIT_OVF        4
`define LSFU_BIT_QUOT       5
`define LSFU_FLAG_COUNT     6

// Reset values
`define LSFU_RST_STATUS     6'h00
`define LSFU_RST_UNDEF      6'h00
`define LSFU_RST_COMMITS    16'h0000

`endif

// File: lsfu_pkg.sv
package lsfu_pkg;

  // What an instruction does to one flag
  typedef enum logic [1:0] {
    FA_KEEP  = 2'h0,
    FA_CALC  = 2'h1,
    FA_CLEAR = 2'h2,
    FA_UNDEF = 2'h3
  } lsfu_act_e;

  // One action per flag, condition bit lowest
  typedef struct packed {
    lsfu_act_e quot;
    lsfu_act_e ovf;
    lsfu_act_e carry;
    lsfu_act_e neg;
    lsfu_act_e zero;
    lsfu_act_e cond;
  } lsfu_plan_s;

  // The six status flags, packed in status-word order
  typedef struct packed {
    logic quotient_flag;
    logic overflow_copy;
    logic carry_copy;
    logic negative_flag;
    logic zero_flag;
    logic condition_bit;
  } lsfu_flags_s;

  // Side values from the datapath for the flags not derived from the result word
  typedef struct packed {
    logic cond;
    logic carry;
    logic ovf;
    logic quot;
  } lsfu_side_s;

  // Instruction classes delivered by the decoder
  typedef enum logic [5:0] {
    IC_NONE        = 6'h00,
    IC_MOV_ACC     = 6'h01,
    IC_MOV_COND    = 6'h02,
    IC_MOV_HZX     = 6'h03,
    IC_MOV_HSX     = 6'h04,
    IC_MOVH_REG    = 6'h05,
    IC_MOVH_ACC    = 6'h06,
    IC_MOV_BZX     = 6'h07,
    IC_MOV_BSX     = 6'h08,
    IC_CMP_DREG    = 6'h09,
    IC_CMP_PTR     = 6'h0a,
    IC_CMP_ACC     = 6'h0b,
    IC_MOV_CC      = 6'h0c,
    IC_NEG_CC      = 6'h0d,
    IC_LOGIC       = 6'h0e,
    IC_BXOR        = 6'h0f,
    IC_BITCLR      = 6'h10,
    IC_BITSET      = 6'h11,
    IC_BITTGL      = 6'h12,
    IC_BITTST      = 6'h13,
    IC_DEP_EXT     = 6'h14,
    IC_BITMUX      = 6'h15,
    IC_ADDSH_PREG  = 6'h16,
    IC_ADDSH_DREG  = 6'h17,
    IC_SHADD       = 6'h18,
    IC_ASH_DREG    = 6'h19,
    IC_ASH_ACC     = 6'h1a,
    IC_LSH_PREG    = 6'h1b,
    IC_LSH_DREG    = 6'h1c,
    IC_LSH_ACC     = 6'h1d,
    IC_ROT         = 6'h1e,
    IC_ABS_DREG    = 6'h1f,
    IC_ABS_ACC     = 6'h20,
    IC_ADD_PREG    = 6'h21,
    IC_ADD_DREG    = 6'h22,
    IC_PRESCALE    = 6'h23,
    IC_ADDI_PREG   = 6'h24,
    IC_ADDI_DREG   = 6'h25,
    IC_DIVIDE      = 6'h26,
    IC_EXPADJ      = 6'h27,
    IC_MAXMIN      = 6'h28,
    IC_MODD_PREG   = 6'h29,
    IC_MODD_ACC    = 6'h2a,
    IC_MODI_PREG   = 6'h2b,
    IC_MODI_DREG   = 6'h2c,
    IC_MODI_ACC    = 6'h2d,
    IC_MUL16       = 6'h2e,
    IC_MUL32       = 6'h2f,
    IC_MAC         = 6'h30,
    IC_NEG_DREG    = 6'h31,
    IC_NEG_ACC     = 6'h32,
    IC_RND         = 6'h33,
    IC_SAT         = 6'h34,
    IC_SUB         = 6'h35,
    IC_SUBI        = 6'h36,
    IC_CONTROL     = 6'h37
  } lsfu_iclass_e;

endpackage

// File: lsfu_flag_update.sv
`include "lsfu_map.svh"

// Behaviour
// - Mac to data register move: zero, negative, overflow undefined; others kept.
// - Zero-extend half move: zero computed; negative, carry, overflow cleared.
// - Sign-extend half move: zero, negative computed; carry, overflow cleared.
// - Other half moves not sourced from a mac register keep every flag.
// - Mac to half data register: zero, negative, overflow undefined; others kept.
// - Add-with-shift: pointer form keeps all; data form computes, carry undefined.
// - Arithmetic shift to data: zero, negative, overflow computed; carry undefined.
// - Arithmetic shift to mac: zero, negative computed; carry undefined; overflow kept.
// - Logical shift to pointer: zero, negative, carry, overflow undefined.
// - Logical shift to data: zero, negative computed; carry kept; overflow undefined.
// - Add immediate: data form computes four flags; pointer or index keeps all.
// - Divide steps compute quotient; four flags undefined; condition kept.
// - Modify-increment extracted to data computes zero, negative, carry, overflow.
// - Modify-decrement of mac: zero, negative, carry undefined; overflow kept.
// - Multiply to mac makes only overflow undefined; all else kept.
// - Negate to data: zero, negative, overflow computed; carry undefined.
// - Round to half-word: zero, negative, overflow computed; carry undefined.
// - Prescaled add and subtract, up and down, keep all flags.
// - Forced interrupt or reset instruction alters no flag.
// - A flag marked cleared is written zero whatever the result.
// - Undefined flags may take any value; software samples them beforehand.
module lsfu_flag_update #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
) (
  // Clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // Instruction write-back from decoder and datapath
  input  wire logic                 wb_valid,
  input  wire lsfu_pkg::lsfu_iclass_e wb_class,
  input  wire logic [DATA_W-1:0]    wb_result,
  input  wire logic                 wb_half,
  input  wire lsfu_pkg::lsfu_side_s wb_side,
  // Register port
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output lsfu_pkg::lsfu_flags_s     arith_status_word,
  output logic [`LSFU_FLAG_COUNT-1:0] undef_mask,
  output logic [31:0]               reg_rdata
);

  localparam lsfu_pkg::lsfu_act_e K = lsfu_pkg::FA_KEEP;
  localparam lsfu_pkg::lsfu_act_e C = lsfu_pkg::FA_CALC;
  localparam lsfu_pkg::lsfu_act_e Z = lsfu_pkg::FA_CLEAR;
  localparam lsfu_pkg::lsfu_act_e U = lsfu_pkg::FA_UNDEF;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Builds a plan; argument order follows the flag columns cond..quot
  function automatic lsfu_pkg::lsfu_plan_s mk(
    input lsfu_pkg::lsfu_act_e cc,
    input lsfu_pkg::lsfu_act_e zr,
    input lsfu_pkg::lsfu_act_e ng,
    input lsfu_pkg::lsfu_act_e cy,
    input lsfu_pkg::lsfu_act_e ov,
    input lsfu_pkg::lsfu_act_e qt
  );
    mk = '{quot: qt, ovf: ov, carry: cy, neg: ng, zero: zr, cond: cc};
  endfunction

  // Applies one action to one flag
  function automatic logic apply(
    input lsfu_pkg::lsfu_act_e act,
    input logic                old_v,
    input logic                calc_v
  );
    unique case (act)
      lsfu_pkg::FA_KEEP:  apply = old_v;
      lsfu_pkg::FA_CALC:  apply = calc_v;
      lsfu_pkg::FA_CLEAR: apply = 1'b0;
      lsfu_pkg::FA_UNDEF: apply = calc_v;
    endcase
  endfunction

  // Marks an undefined flag
  function automatic logic is_undef(input lsfu_pkg::lsfu_act_e act);
    is_undef = (act == lsfu_pkg::FA_UNDEF);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Class to per-flag action table

  function automatic lsfu_pkg::lsfu_plan_s plan_of(input lsfu_pkg::lsfu_iclass_e ic);
    unique case (ic)
      lsfu_pkg::IC_MOV_ACC:    plan_of = mk(K, U, U, K, U, K);
      lsfu_pkg::IC_MOV_COND:   plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_MOV_HZX:    plan_of = mk(K, C, Z, Z, Z, K);
      lsfu_pkg::IC_MOV_HSX:    plan_of = mk(K, C, C, Z, Z, K);
      lsfu_pkg::IC_MOVH_REG:   plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_MOVH_ACC:   plan_of = mk(K, U, U, K, U, K);
      lsfu_pkg::IC_MOV_BZX:    plan_of = mk(K, C, C, Z, Z, K);
      lsfu_pkg::IC_MOV_BSX:    plan_of = mk(K, C, C, Z, Z, K);
      lsfu_pkg::IC_CMP_DREG:   plan_of = mk(C, C, C, C, U, K);
      lsfu_pkg::IC_CMP_PTR:    plan_of = mk(C, K, K, K, K, K);
      lsfu_pkg::IC_CMP_ACC:    plan_of = mk(C, C, C, C, U, K);
      lsfu_pkg::IC_MOV_CC:     plan_of = mk(K, C, C, C, C, C);
      lsfu_pkg::IC_NEG_CC:     plan_of = mk(C, K, K, K, K, K);
      lsfu_pkg::IC_LOGIC:      plan_of = mk(K, C, C, Z, Z, K);
      lsfu_pkg::IC_BXOR:       plan_of = mk(C, K, K, K, K, K);
      lsfu_pkg::IC_BITCLR:     plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_BITSET:     plan_of = mk(K, U, U, U, U, K);
      lsfu_pkg::IC_BITTGL:     plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_BITTST:     plan_of = mk(C, K, K, K, K, K);
      lsfu_pkg::IC_DEP_EXT:    plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_BITMUX:     plan_of = mk(K, U, U, K, K, K);
      lsfu_pkg::IC_ADDSH_PREG: plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_ADDSH_DREG: plan_of = mk(K, C, C, U, C, K);
      lsfu_pkg::IC_SHADD:      plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_ASH_DREG:   plan_of = mk(K, C, C, U, C, K);
      lsfu_pkg::IC_ASH_ACC:    plan_of = mk(K, C, C, U, K, K);
      lsfu_pkg::IC_LSH_PREG:   plan_of = mk(K, U, U, U, U, K);
      lsfu_pkg::IC_LSH_DREG:   plan_of = mk(K, C, C, K, U, K);
      lsfu_pkg::IC_LSH_ACC:    plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_ROT:        plan_of = mk(C, K, K, K, K, K);
      lsfu_pkg::IC_ABS_DREG:   plan_of = mk(K, C, Z, U, C, K);
      lsfu_pkg::IC_ABS_ACC:    plan_of = mk(K, C, Z, U, U, K);
      lsfu_pkg::IC_ADD_PREG:   plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_ADD_DREG:   plan_of = mk(K, C, C, C, C, K);
      lsfu_pkg::IC_PRESCALE:   plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_ADDI_PREG:  plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_ADDI_DREG:  plan_of = mk(K, C, C, C, C, K);
      lsfu_pkg::IC_DIVIDE:     plan_of = mk(K, U, U, U, U, C);
      lsfu_pkg::IC_EXPADJ:     plan_of = mk(K, U, U, K, K, K);
      lsfu_pkg::IC_MAXMIN:     plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_MODD_PREG:  plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_MODD_ACC:   plan_of = mk(K, U, U, U, K, K);
      lsfu_pkg::IC_MODI_PREG:  plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_MODI_DREG:  plan_of = mk(K, C, C, C, C, K);
      lsfu_pkg::IC_MODI_ACC:   plan_of = mk(K, U, U, U, U, K);
      lsfu_pkg::IC_MUL16:      plan_of = mk(K, K, K, K, U, K);
      lsfu_pkg::IC_MUL32:      plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_MAC:        plan_of = mk(K, K, K, K, U, K);
      lsfu_pkg::IC_NEG_DREG:   plan_of = mk(K, C, C, U, C, K);
      lsfu_pkg::IC_NEG_ACC:    plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_RND:        plan_of = mk(K, C, C, U, C, K);
      lsfu_pkg::IC_SAT:        plan_of = mk(K, C, C, U, U, K);
      lsfu_pkg::IC_SUB:        plan_of = mk(K, C, C, C, C, K);
      lsfu_pkg::IC_SUBI:       plan_of = mk(K, K, K, K, K, K);
      lsfu_pkg::IC_CONTROL:    plan_of = mk(K, K, K, K, K, K);
      default:                 plan_of = mk(K, K, K, K, K, K);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Flag values computed from the result word and the side values

  lsfu_pkg::lsfu_plan_s  plan;
  lsfu_pkg::lsfu_flags_s calc;
  lsfu_pkg::lsfu_flags_s flags_next;
  logic [`LSFU_FLAG_COUNT-1:0] undef_next;
  logic                  commit;
  logic [CNT_W-1:0]      commit_cnt_reg;

  assign plan   = plan_of(wb_class);
  assign commit = clk_en && wb_valid;

  always_comb
  begin
    calc.condition_bit = wb_side.cond;
    calc.zero_flag     = wb_half ? (wb_result[15:0] == 16'h0000) : (wb_result == '0);
    calc.negative_flag = wb_half ? wb_result[15] : wb_result[DATA_W-1];
    calc.carry_copy    = wb_side.carry;
    calc.overflow_copy = wb_side.ovf;
    calc.quotient_flag = wb_side.quot;
  end

  always_comb
  begin
    flags_next.condition_bit = apply(plan.cond, arith_status_word.condition_bit,
                                     calc.condition_bit);
    flags_next.zero_flag     = apply(plan.zero, arith_status_word.zero_flag,
                                     calc.zero_flag);
    flags_next.negative_flag = apply(plan.neg, arith_status_word.negative_flag,
                                     calc.negative_flag);
    flags_next.carry_copy    = apply(plan.carry, arith_status_word.carry_copy,
                                     calc.carry_copy);
    flags_next.overflow_copy = apply(plan.ovf, arith_status_word.overflow_copy,
                                     calc.overflow_copy);
    flags_next.quotient_flag = apply(plan.quot, arith_status_word.quotient_flag,
                                     calc.quotient_flag);
    undef_next = {is_undef(plan.quot), is_undef(plan.ovf), is_undef(plan.carry),
                  is_undef(plan.neg), is_undef(plan.zero), is_undef(plan.cond)};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word: instruction commit wins over a software write in the same cycle

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      arith_status_word <= `LSFU_RST_STATUS;
    else if (commit)
      arith_status_word <= flags_next;
    else if (clk_en && reg_wr && reg_addr == `LSFU_OFS_STATUS)
      arith_status_word <= reg_wdata[`LSFU_FLAG_COUNT-1:0];
  end

  // Undefined mask: set by the committing instruction, kept flags keep their mark
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      undef_mask <= `LSFU_RST_UNDEF;
    else if (commit)
      undef_mask <= undef_next | (undef_mask & ~defined_by(plan));
    else if (clk_en && reg_wr && reg_addr == `LSFU_OFS_STATUS)
      undef_mask <= `LSFU_RST_UNDEF;
  end

  // Flags touched by the plan with a defined outcome lose their undefined mark
  function automatic logic [`LSFU_FLAG_COUNT-1:0] defined_by(input lsfu_pkg::lsfu_plan_s p);
    defined_by = {p.quot != K, p.ovf != K, p.carry != K,
                  p.neg != K, p.zero != K, p.cond != K};
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      commit_cnt_reg <= `LSFU_RST_COMMITS;
    else if (commit)
      commit_cnt_reg <= commit_cnt_reg + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after an enabled strobe, held while clk_en stays low

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `LSFU_OFS_STATUS:  reg_rdata <= {26'h0, arith_status_word};
          `LSFU_OFS_UNDEF:   reg_rdata <= {26'h0, undef_mask};
          `LSFU_OFS_COMMITS: reg_rdata <= {{(32-CNT_W){1'b0}}, commit_cnt_reg};
          default:           reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// File: lsfu_monitor.sv
module lsfu_monitor #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  // Write-back
  input wire logic                   clk_en,
  input wire logic                   wb_valid,
  input wire lsfu_pkg::lsfu_iclass_e wb_class,
  input wire logic [DATA_W-1:0]      wb_result,
  input wire logic                   wb_half,
  input wire lsfu_pkg::lsfu_side_s   wb_side,
  // Flag state
  input wire lsfu_pkg::lsfu_flags_s  arith_status_word,
  input wire logic [5:0]             undef_mask
);
  logic       go;
  logic       zn;
  logic       nn;
  logic [5:0] st;

  // Zero and negative as the result word shows them
  assign go = wb_valid & clk_en;
  assign zn = wb_half ? ~|wb_result[15:0] : ~|wb_result;
  assign nn = wb_half ? wb_result[15] : wb_result[DATA_W-1];
  assign st = arith_status_word;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  keep_all_a:
    assert property (go && wb_class inside {lsfu_pkg::IC_MOV_COND, lsfu_pkg::IC_MOVH_REG,
      lsfu_pkg::IC_PRESCALE, lsfu_pkg::IC_CONTROL} |=> $stable(st) && $stable(undef_mask))
    else $error("flags changed on a keep-all class");
  zero_ext_a:
    assert property (go && wb_class == lsfu_pkg::IC_MOV_HZX |=>
      st[4:1] == {3'h0, $past(zn)} && undef_mask[4:1] == 4'h0)
    else $error("zero-extend move flags wrong");
  sign_ext_a:
    assert property (go && wb_class == lsfu_pkg::IC_MOV_HSX |=>
      st[4:1] == {2'h0, $past(nn), $past(zn)} && undef_mask[4:1] == 4'h0)
    else $error("sign-extend move flags wrong");
  acc_move_a:
    assert property (go && wb_class inside {lsfu_pkg::IC_MOV_ACC, lsfu_pkg::IC_MOVH_ACC} |=>
      undef_mask == ($past(undef_mask) | 6'h16) && (st & 6'h29) == ($past(st) & 6'h29))
    else $error("mac move flags wrong");
  calc_carry_a:
    assert property (go && wb_class inside {lsfu_pkg::IC_ADDSH_DREG, lsfu_pkg::IC_ASH_DREG,
      lsfu_pkg::IC_NEG_DREG, lsfu_pkg::IC_RND} |=> st[2:1] == {$past(nn), $past(zn)} &&
      st[4] == $past(wb_side.ovf) && undef_mask[4:1] == 4'h4)
    else $error("carry-undefined class flags wrong");
  lsh_ptr_a:
    assert property (go && wb_class == lsfu_pkg::IC_LSH_PREG |=>
      undef_mask == ($past(undef_mask) | 6'h1e) && (st & 6'h21) == ($past(st) & 6'h21))
    else $error("pointer logical shift flags wrong");
  lsh_data_a:
    assert property (go && wb_class == lsfu_pkg::IC_LSH_DREG |=> $stable(st[3]) &&
      st[2:1] == {$past(nn), $past(zn)} && undef_mask[4] && undef_mask[2:1] == 2'h0)
    else $error("data logical shift flags wrong");
  divide_step_a:
    assert property (go && wb_class == lsfu_pkg::IC_DIVIDE |=> st[5] == $past(wb_side.quot)
      && $stable(st[0]) && undef_mask[5:1] == 5'h0f)
    else $error("divide step flags wrong");
  add_imm_a:
    assert property (go && wb_class inside {lsfu_pkg::IC_ADDI_DREG, lsfu_pkg::IC_MODI_DREG}
      |=> st[4:1] == {$past(wb_side.ovf), $past(wb_side.carry), $past(nn), $past(zn)})
    else $error("add immediate flags wrong");
endmodule

bind lsfu_flag_update lsfu_monitor #(.DATA_W(DATA_W)) i_lsfu_monitor (
  .core_clk, .sys_rst, .clk_en, .wb_valid, .wb_class, .wb_result, .wb_half, .wb_side,
  .arith_status_word, .undef_mask
);

// File: tb.sv
`include "lsfu_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk;
  logic                   sys_rst;
  logic                   clk_en;
  logic                   wb_valid;
  lsfu_pkg::lsfu_iclass_e wb_class;
  lsfu_pkg::lsfu_iclass_e cls;
  logic [31:0]            wb_result;
  logic                   wb_half;
  lsfu_pkg::lsfu_side_s   wb_side;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  lsfu_pkg::lsfu_flags_s  arith_status_word;
  logic [5:0]             undef_mask;
  logic [31:0]            reg_rdata;
  logic [5:0]             exp_st;
  logic [5:0]             exp_un;
  logic [15:0]            exp_cnt;
  logic [31:0]            rd_exp;
  logic [31:0]            rd_msk;
  logic                   rd_pend;
  logic [31:0]            op;
  int                     mismatches;
  int                     samples_checked;
  int                     seed;

  lsfu_flag_update i_lsfu_flag_update (
    .core_clk, .sys_rst, .clk_en, .wb_valid, .wb_class, .wb_result, .wb_half, .wb_side,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .arith_status_word, .undef_mask, .reg_rdata
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Per flag, condition bit first: Keep, Calc, Zero-forced, Undefined
  function automatic string plan(lsfu_pkg::lsfu_iclass_e c);
    case (c)
      lsfu_pkg::IC_NONE, lsfu_pkg::IC_MOV_COND, lsfu_pkg::IC_MOVH_REG, lsfu_pkg::IC_ADDSH_PREG,
      lsfu_pkg::IC_ADDI_PREG, lsfu_pkg::IC_PRESCALE, lsfu_pkg::IC_CONTROL,
      lsfu_pkg::IC_SHADD, lsfu_pkg::IC_ADD_PREG, lsfu_pkg::IC_MODD_PREG,
      lsfu_pkg::IC_MODI_PREG, lsfu_pkg::IC_MUL32, lsfu_pkg::IC_SUBI: return "KKKKKK";
      lsfu_pkg::IC_MOV_BZX, lsfu_pkg::IC_MOV_BSX, lsfu_pkg::IC_LOGIC: return "KCCZZK";
      lsfu_pkg::IC_CMP_DREG, lsfu_pkg::IC_CMP_ACC: return "CCCCUK";
      lsfu_pkg::IC_CMP_PTR, lsfu_pkg::IC_NEG_CC, lsfu_pkg::IC_BXOR, lsfu_pkg::IC_BITTST,
      lsfu_pkg::IC_ROT: return "CKKKKK";
      lsfu_pkg::IC_MOV_CC: return "KCCCCC";
      lsfu_pkg::IC_BITCLR, lsfu_pkg::IC_BITTGL, lsfu_pkg::IC_DEP_EXT, lsfu_pkg::IC_LSH_ACC,
      lsfu_pkg::IC_NEG_ACC, lsfu_pkg::IC_MAXMIN, lsfu_pkg::IC_SAT: return "KCCUUK";
      lsfu_pkg::IC_BITSET, lsfu_pkg::IC_MODI_ACC: return "KUUUUK";
      lsfu_pkg::IC_BITMUX, lsfu_pkg::IC_EXPADJ: return "KUUKKK";
      lsfu_pkg::IC_ABS_DREG: return "KCZUCK";
      lsfu_pkg::IC_ABS_ACC: return "KCZUUK";
      lsfu_pkg::IC_ADD_DREG, lsfu_pkg::IC_SUB: return "KCCCCK";
      lsfu_pkg::IC_MUL16: return "KKKKUK";
      lsfu_pkg::IC_MOV_ACC, lsfu_pkg::IC_MOVH_ACC: return "KUUKUK";
      lsfu_pkg::IC_MOV_HZX: return "KCZZZK";
      lsfu_pkg::IC_MOV_HSX: return "KCCZZK";
      lsfu_pkg::IC_ADDSH_DREG, lsfu_pkg::IC_ASH_DREG,
      lsfu_pkg::IC_NEG_DREG, lsfu_pkg::IC_RND: return "KCCUCK";
      lsfu_pkg::IC_ASH_ACC: return "KCCUKK";
      lsfu_pkg::IC_LSH_PREG: return "KUUUUK";
      lsfu_pkg::IC_LSH_DREG: return "KCCKUK";
      lsfu_pkg::IC_ADDI_DREG, lsfu_pkg::IC_MODI_DREG: return "KCCCCK";
      lsfu_pkg::IC_DIVIDE: return "KUUUUC";
      lsfu_pkg::IC_MODD_ACC: return "KUUUKK";
      lsfu_pkg::IC_MAC: return "KKKKUK";
      default: return "";
    endcase
  endfunction

  task automatic model(lsfu_pkg::lsfu_iclass_e c, logic [31:0] r, logic h,
                       lsfu_pkg::lsfu_side_s s);
    string      p;
    logic [5:0] cv;
    p = plan(c);
    cv = {s.quot, s.ovf, s.carry, h ? r[15] : r[31], h ? r[15:0] == 16'h0 : r == 32'h0, s.cond};
    for (int i = 0; i < 6; i++)
    begin
      exp_st[i] = p[i] == "C" ? cv[i] : p[i] == "Z" ? 1'b0 : exp_st[i];
      exp_un[i] = p[i] == "U" ? 1'b1 : p[i] == "K" ? exp_un[i] : 1'b0;
    end
    exp_cnt++;
  endtask

  // One cycle of requests; checks what the previous edge committed
  task automatic step(logic v, lsfu_pkg::lsfu_iclass_e c, logic [31:0] r, logic h,
                      lsfu_pkg::lsfu_side_s s, logic w, logic rd, logic [7:0] a, logic [31:0] d);
    wb_valid <= v;
    wb_class <= c;
    wb_result <= r;
    wb_half <= h;
    wb_side <= s;
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge core_clk);
    chk("status", 32'(arith_status_word & ~exp_un), 32'(exp_st & ~exp_un));
    chk("undef_mask", 32'(undef_mask), 32'(exp_un));
    if (rd_pend)
      chk("reg_rdata", reg_rdata & rd_msk, rd_exp & rd_msk);
    @(posedge core_clk);
    rd_pend = rd & clk_en;
    rd_msk = a == `LSFU_OFS_STATUS ? {26'h3ffffff, ~exp_un} : 32'hffffffff;
    rd_exp = a == `LSFU_OFS_STATUS ? 32'(exp_st) : a == `LSFU_OFS_UNDEF ? 32'(exp_un) :
             a == `LSFU_OFS_COMMITS ? 32'(exp_cnt) : 32'h0;
    if (clk_en && v)
      model(c, r, h, s);
    else if (clk_en && w && a == `LSFU_OFS_STATUS)
    begin
      exp_st = d[5:0];
      exp_un = 6'h00;
    end
  endtask

  task automatic nop();
    step(1'b0, lsfu_pkg::IC_NONE, 32'h0, 1'b0, 4'h0, 1'b0, 1'b0, 8'h00, 32'h0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h377d;
    {mismatches, samples_checked, exp_st, exp_un, exp_cnt, rd_pend} = '0;
    {sys_rst, clk_en} = 2'b11;
    {wb_valid, wb_result, wb_half, wb_side, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    wb_class = lsfu_pkg::IC_NONE;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int k = 0; k < 4; k++)
      step(1'b0, lsfu_pkg::IC_NONE, 32'h0, 1'b0, 4'h0, 1'b0, 1'b1, 8'(4 * k), 32'h0);
    step(1'b0, lsfu_pkg::IC_NONE, 32'h0, 1'b0, 4'h0, 1'b1, 1'b0, `LSFU_OFS_STATUS, 32'h3f);
    step(1'b1, lsfu_pkg::IC_MOV_HZX, 32'h80000000, 1'b0, 4'hf, 1'b0, 1'b0, 8'h00, 32'h0);
    step(1'b1, lsfu_pkg::IC_MOV_HSX, 32'h00018000, 1'b1, 4'h0, 1'b0, 1'b1, 8'h00, 32'h0);
    step(1'b1, lsfu_pkg::IC_MOV_COND, 32'h0, 1'b0, 4'h0, 1'b1, 1'b0, 8'h00, 32'h0);
    step(1'b0, lsfu_pkg::IC_NONE, 32'h0, 1'b0, 4'h0, 1'b1, 1'b0, `LSFU_OFS_UNDEF, 32'hff);
    for (int k = 0; k < 64; k++)
      if (plan(lsfu_pkg::lsfu_iclass_e'(k)) != "")
        step(1'b1, lsfu_pkg::lsfu_iclass_e'(k), k[1] ? $random(seed) : 32'hffff0000, k[0],
             k[3:0], 1'b0, 1'b1, {4'h0, k[3:2], 2'h0}, 32'h0);
    // Second reset in mid-run
    nop();
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    {exp_st, exp_un, exp_cnt, rd_pend} = '0;
    @(posedge core_clk);
    repeat (400)
    begin
      op = $random(seed);
      cls = lsfu_pkg::lsfu_iclass_e'(op[10:5]);
      if (plan(cls) == "")
        cls = lsfu_pkg::IC_NONE;
      clk_en <= op[2:0] != 3'h0;
      step(op[3] | op[4], cls, $random(seed), op[11], op[15:12], op[16] & op[17],
           op[18] & ~op[17], {4'h0, op[20:19], 2'h0}, $random(seed));
    end
    clk_en <= 1'b1;
    nop();
    nop();
    give_verdict();
  end
endmodule
